// ### shared/sercfg_pkg.sv
// Package for the serializer configuration and status register slice.
// Assumes an 8-bit register address and data path from the serial
// control slave.
`default_nettype none

package sercfg_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LOW_TIME = 8'h19;
    localparam logic [7:0] ADDR_DP_CTRL = 8'h1A;
    localparam logic [7:0] ADDR_ERR_COUNT = 8'h1B;
    localparam logic [7:0] ADDR_PIN_ONE = 8'h1C;
    localparam logic [7:0] ADDR_PIN_TWO = 8'h1D;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LOW_TIME = 8'h7F;
    localparam logic [7:0] RST_DP_CTRL = 8'h01;
    localparam logic [7:0] RST_ERR_COUNT = 8'h00;
    localparam logic [7:0] ERR_COUNT_MAX = 8'hFF;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DP_SURROUND_BIT = 0;
    localparam int DP_WIDE_BIT = 1;
    localparam int DP_AUX_BIT = 3;
    localparam int PIN_RSVD_BIT = 4;
    localparam int PIN_HIGH_LSB = 5;
    localparam int PIN_EIGHT = 8;
    localparam int PIN_TOTAL = 9;
    localparam int PIN_LOW_COUNT = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int OSC_PERIOD_NS = 40;
    localparam int CLK_FREQ_KHZ = 25000;
    localparam int LOW_EXTRA_PERIODS = 5;
    localparam int LOW_UNIT_RAW =
        (OSC_PERIOD_NS * CLK_FREQ_KHZ + 999999) / 1000000;
    localparam int LOW_UNIT_CYCLES = (LOW_UNIT_RAW < 1) ? 1 : LOW_UNIT_RAW;

endpackage

`default_nettype wire

// ### hw/sercfg_low_timer.sv
// Low-time timer: one pulse after (count + extra) oscillator periods.
// Assumes start is a one-cycle pulse and count is stable with it.
`timescale 1ns/1ps
`default_nettype none

module sercfg_low_timer
    import sercfg_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire logic [W-1:0] count,
    // Answer
    output logic done
);

    localparam int TW = W + 4;

    generate
        if (W < 1 || W > 16) begin : g_bad_width
            $error("sercfg_low_timer: W out of range");
        end
    endgenerate

    logic [TW-1:0] remain;
    logic busy;
    logic [TW-1:0] elapsed;
    logic [TW-1:0] target_q;

    // ------------------------------------------------------------
    // Count plus extra periods, scaled to clock cycles
    // ------------------------------------------------------------
    wire [TW-1:0] target = TW'((TW'(count) + TW'(LOW_EXTRA_PERIODS))
                               * TW'(LOW_UNIT_CYCLES));
    wire last = busy && (remain == TW'(1));
    wire next_busy = start | (busy & ~last);
    wire [TW-1:0] next_remain = start ? target :
                                busy ? TW'(remain - TW'(1)) : remain;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            remain <= next_remain;
            busy <= next_busy;
            done <= last & ~start;
        end
    end

    // Helper for checking the measured length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed <= '0;
            target_q <= '0;
        end else if (start) begin
            elapsed <= '0;
            target_q <= target;
        end else if (busy) begin
            elapsed <= TW'(elapsed + TW'(1));
        end
    end

    low_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        done |-> elapsed == target_q)
        else $error("low time length differs from count plus five");

    low_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        done |-> $past(busy) && !busy)
        else $error("low time end without a running timer");

endmodule // sercfg_low_timer

`default_nettype wire

// ### hw/sercfg_regs.sv
// Configuration and status register slice of the serializer.
// Assumes the serial control slave presents decoded 8-bit register
// accesses on this clock, and pin input modes are on this clock; pin levels pass through two-flop synchronizers.
//
// Functional notes
// - Master clock low width comes from 8-bit RW field, reset 0x7F.
// - One field count equals one 40 ns oscillator period at 25 MHz.
// - Generated low time is programmed count plus five extra periods.
// - Slave data setup on back-channel accesses reuses the low-time value.
// - Control bit 3 is read-only, showing auxiliary audio enable.
// - Auxiliary audio control loads from the strap pin at power-up.
// - Control bit 1 picks 24-bit plus sync signals or 28-bit words.
// - Control bit 0 picks stereo/quad or 5.1/7.1 audio transport.
// - Surround audio travels only over the data-island transport.
// - Repeater may override surround bit with in-band mode detection.
// - Self-test CRC errors counted in 8 bits from zero, saturating.
// - Error count clears on new self test or clear control.
// - Second-port view shows the second link's error count.
// - Pin status register shows pins seven, six, five; bit 4 reserved.
// - Low four status bits show pins three..zero, or second port's.
// - A pin status bit is valid only in input mode.
// - Second status register bit 0 shows pin eight; upper bits reserved.
// - View select routes accesses to second-port registers unless the second address is enabled; then only that address does.
`timescale 1ns/1ps
`default_nettype none

module sercfg_regs
    import sercfg_pkg::*;
#(
    parameter int LOW_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register access from the serial control slave
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Port view
    input wire logic second_port_view_select,
    input wire logic second_address_enable,
    input wire logic access_via_second_address,
    // Strap and bridge configuration
    input wire logic strap_select_pin_zero,
    input wire logic bridge_aux_write,
    input wire logic bridge_aux_wdata,
    // Audio transport
    input wire logic repeater_mode,
    input wire logic inband_detect_valid,
    input wire logic inband_surround,
    input wire logic data_island_transport,
    // Self test
    input wire logic selftest_active,
    input wire logic selftest_start,
    input wire logic error_count_clear,
    input wire logic [1:0] bc_crc_error,
    // General pins
    input wire logic [PIN_TOTAL-1:0] general_pin_level,
    input wire logic [PIN_TOTAL-1:0] pin_input_mode,
    input wire logic [PIN_LOW_COUNT-1:0] second_port_pin_level,
    input wire logic [PIN_LOW_COUNT-1:0] second_port_input_mode,
    // Low-time timers
    input wire logic master_low_start,
    output logic master_low_done,
    input wire logic bc_setup_start,
    output logic bc_setup_done,
    // Data path controls
    output logic wide_word_mode,
    output logic surround_audio_enable,
    output logic aux_audio_enable
);

    generate
        if (LOW_W != 8) begin : g_bad_low
            $error("sercfg_regs: LOW_W must be 8");
        end
    endgenerate

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    function automatic logic [PIN_TOTAL-1:0] valid_levels(
        input logic [PIN_TOTAL-1:0] lvl, input logic [PIN_TOTAL-1:0] mode);
        valid_levels = lvl & mode;
    endfunction

    wire wr_low = reg_wr && hit(reg_addr, ADDR_LOW_TIME);
    wire wr_dp = reg_wr && hit(reg_addr, ADDR_DP_CTRL);
    // Separate address wins over the select bit when enabled
    wire view_second = second_address_enable ? access_via_second_address
                                             : second_port_view_select;

    // ------------------------------------------------------------
    // Writable fields
    // ------------------------------------------------------------
    logic [LOW_W-1:0] master_clock_low_time;
    logic surround_select;
    logic strap_taken;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            master_clock_low_time <= RST_LOW_TIME;
            wide_word_mode <= RST_DP_CTRL[DP_WIDE_BIT];
            surround_select <= RST_DP_CTRL[DP_SURROUND_BIT];
        end else begin
            if (wr_low) begin
                master_clock_low_time <= reg_wdata;
            end
            if (wr_dp) begin
                // Only bits 1 and 0 take the write
                wide_word_mode <= reg_wdata[DP_WIDE_BIT];
                surround_select <= reg_wdata[DP_SURROUND_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Auxiliary audio control and strap capture
    // ------------------------------------------------------------
    wire next_aux = !strap_taken ? strap_select_pin_zero :
                    bridge_aux_write ? bridge_aux_wdata : aux_audio_enable;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_taken <= 1'b0;
            aux_audio_enable <= 1'b0;
        end else begin
            strap_taken <= 1'b1;
            aux_audio_enable <= next_aux;
        end
    end

    // ------------------------------------------------------------
    // Surround audio transport
    // ------------------------------------------------------------
    wire surround_pick = (repeater_mode && inband_detect_valid) ?
                         inband_surround : surround_select;
    wire next_surround = surround_pick & data_island_transport;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            surround_audio_enable <= 1'b0;
        end else begin
            surround_audio_enable <= next_surround;
        end
    end

    // ------------------------------------------------------------
    // Back-channel error counters, one per link
    // ------------------------------------------------------------
    logic [7:0] err_count [2];

    generate
        for (genvar p = 0; p < 2; p++) begin : g_err
            wire err_evt = selftest_active && bc_crc_error[p];
            wire clr = selftest_start || error_count_clear;
            wire at_max = (err_count[p] == ERR_COUNT_MAX);
            // An error in the clearing cycle still counts
            wire [7:0] next_count =
                clr ? (err_evt ? 8'h01 : RST_ERR_COUNT) :
                (err_evt && !at_max) ? 8'(err_count[p] + 8'h01) :
                err_count[p];

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    err_count[p] <= RST_ERR_COUNT;
                end else begin
                    err_count[p] <= next_count;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin level synchronizers
    // ------------------------------------------------------------
    localparam int SYNC_W = PIN_TOTAL + PIN_LOW_COUNT;
    logic [SYNC_W-1:0] pin_meta;
    logic [SYNC_W-1:0] pin_sync;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {second_port_pin_level, general_pin_level};
            pin_sync <= pin_meta;
        end
    end

    wire [PIN_TOTAL-1:0] main_valid =
        valid_levels(pin_sync[PIN_TOTAL-1:0], pin_input_mode);
    wire [PIN_LOW_COUNT-1:0] second_valid =
        pin_sync[SYNC_W-1:PIN_TOTAL] & second_port_input_mode;
    wire [PIN_LOW_COUNT-1:0] low_pins = view_second ? second_valid
        : main_valid[PIN_LOW_COUNT-1:0];

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire [7:0] rd_low = master_clock_low_time;
    wire [7:0] rd_dp = {4'h0, aux_audio_enable, 1'b0, wide_word_mode,
                        surround_select};
    wire [7:0] rd_err = view_second ? err_count[1] : err_count[0];
    wire [7:0] rd_pin_one = {main_valid[PIN_EIGHT-1:PIN_HIGH_LSB], 1'b0,
                             low_pins};
    wire [7:0] rd_pin_two = {7'h00, main_valid[PIN_EIGHT]};
    wire [7:0] next_rdata =
        hit(reg_addr, ADDR_LOW_TIME) ? rd_low :
        hit(reg_addr, ADDR_DP_CTRL) ? rd_dp :
        hit(reg_addr, ADDR_ERR_COUNT) ? rd_err :
        hit(reg_addr, ADDR_PIN_ONE) ? rd_pin_one :
        hit(reg_addr, ADDR_PIN_TWO) ? rd_pin_two : READ_ZERO;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= READ_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Low-time timers
    // ------------------------------------------------------------
    sercfg_low_timer #(.W(LOW_W)) u_master_low (
        .clk(clk),
        .rst_n(rst_n),
        .start(master_low_start),
        .count(master_clock_low_time),
        .done(master_low_done)
    );

    sercfg_low_timer #(.W(LOW_W)) u_setup_low (
        .clk(clk),
        .rst_n(rst_n),
        .start(bc_setup_start),
        .count(master_clock_low_time),
        .done(bc_setup_done)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence dp_write_s;
        wr_dp && !bridge_aux_write;
    endsequence

    low_write_a: assert property (
        wr_low |=> master_clock_low_time == $past(reg_wdata))
        else $error("low-time write not stored");

    wide_mode_a: assert property (
        wr_dp |=> wide_word_mode == $past(reg_wdata[DP_WIDE_BIT]))
        else $error("word format bit not taken from write");

    aux_ro_a: assert property (
        dp_write_s ##0 strap_taken |=> $stable(aux_audio_enable))
        else $error("register write changed auxiliary audio bit");

    surround_gate_a: assert property (
        !data_island_transport |=> !surround_audio_enable)
        else $error("surround enabled without data-island transport");

    err_sat_a: assert property (
        err_count[0] == ERR_COUNT_MAX && !selftest_start
        && !error_count_clear |=> err_count[0] == ERR_COUNT_MAX)
        else $error("error count left saturation");

    err_clear_a: assert property (
        error_count_clear && !bc_crc_error[0] |=> err_count[0] == 8'h00)
        else $error("error count not cleared");

    err_view_a: assert property (
        reg_rd && hit(reg_addr, ADDR_ERR_COUNT) && view_second
        |=> reg_rdata == $past(err_count[1]))
        else $error("second link count not shown");

    pin_mode_a: assert property (
        reg_rd && hit(reg_addr, ADDR_PIN_ONE) && !pin_input_mode[7]
        |=> !reg_rdata[7])
        else $error("pin status shown outside input mode");

    rsvd_zero_a: assert property (
        reg_rd && hit(reg_addr, ADDR_PIN_TWO) |=> reg_rdata[7:1] == 7'h00)
        else $error("reserved bits read nonzero");

endmodule // sercfg_regs

`default_nettype wire

// ### dv/sercfg_regs_tb.sv
// Self-checking testbench for the serializer register slice.
// Assumes sercfg_regs and sercfg_pkg; drives all inputs on falling edges.
`timescale 1ns/1ps
`default_nettype none

module sercfg_regs_tb
    import sercfg_pkg::*;
();
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic view_sel = 1'b0;
    logic addr2_en = 1'b0;
    logic via_addr2 = 1'b0;
    logic strap = 1'b1;
    logic aux_wr = 1'b0;
    logic aux_wdata = 1'b0;
    logic rep_mode = 1'b0;
    logic det_valid = 1'b0;
    logic det_surr = 1'b0;
    logic island = 1'b1;
    logic st_active = 1'b0;
    logic st_start = 1'b0;
    logic cnt_clear = 1'b0;
    logic [1:0] crc_err = 2'b00;
    logic [PIN_TOTAL-1:0] pin_lvl = '0;
    logic [PIN_TOTAL-1:0] pin_mode = '0;
    logic [PIN_LOW_COUNT-1:0] pin2_lvl = '0;
    logic [PIN_LOW_COUNT-1:0] pin2_mode = '0;
    logic m_start = 1'b0;
    logic m_done;
    logic b_start = 1'b0;
    logic b_done;
    logic wide;
    logic surr;
    logic aux;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    sercfg_regs #(.LOW_W(8)) i_sercfg_regs (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .second_port_view_select(view_sel), .second_address_enable(addr2_en),
        .access_via_second_address(via_addr2),
        .strap_select_pin_zero(strap), .bridge_aux_write(aux_wr),
        .bridge_aux_wdata(aux_wdata), .repeater_mode(rep_mode),
        .inband_detect_valid(det_valid), .inband_surround(det_surr),
        .data_island_transport(island), .selftest_active(st_active),
        .selftest_start(st_start), .error_count_clear(cnt_clear),
        .bc_crc_error(crc_err), .general_pin_level(pin_lvl),
        .pin_input_mode(pin_mode), .second_port_pin_level(pin2_lvl),
        .second_port_input_mode(pin2_mode), .master_low_start(m_start),
        .master_low_done(m_done), .bc_setup_start(b_start),
        .bc_setup_done(b_done), .wide_word_mode(wide),
        .surround_audio_enable(surr), .aux_audio_enable(aux)
    );

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    always #20 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: timeout", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                          input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %b exp %b", $time, what,
                     got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic read_expect(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        check8(reg_rdata, exp, "register read");
    endtask

    task automatic timer_run(input bit bc, input int n);
        if (bc) b_start = 1'b1;
        else m_start = 1'b1;
        @(negedge clk);
        b_start = 1'b0;
        m_start = 1'b0;
        for (int k = 1; k <= n; k++) begin
            @(posedge clk);
            #1;
            check1(bc ? b_done : m_done, k == n, "timer done");
        end
        @(negedge clk);
    endtask

    task automatic errors_for(input logic [1:0] e, input int n);
        crc_err = e;
        repeat (n) @(negedge clk);
        crc_err = 2'b00;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        read_expect(ADDR_LOW_TIME, 8'h7F);
        read_expect(ADDR_DP_CTRL, 8'h09);
        read_expect(ADDR_ERR_COUNT, 8'h00);
        read_expect(ADDR_PIN_TWO, 8'h00);
        read_expect(8'h20, 8'h00);
        check1(aux, 1'b1, "aux from strap");
    endtask

    task automatic t_low_time();
        timer_run(0, 132);
        reg_write(ADDR_LOW_TIME, 8'h00);
        read_expect(ADDR_LOW_TIME, 8'h00);
        timer_run(0, 5);
        reg_write(ADDR_LOW_TIME, 8'h03);
        timer_run(1, 8);
    endtask

    task automatic t_data_path();
        reg_write(ADDR_DP_CTRL, 8'hFF);
        read_expect(ADDR_DP_CTRL, 8'h0B);
        check1(wide, 1'b1, "wide word");
        check1(surr, 1'b1, "surround");
        island = 1'b0;
        repeat (2) @(negedge clk);
        check1(surr, 1'b0, "surround off island");
        island = 1'b1;
        rep_mode = 1'b1;
        det_valid = 1'b1;
        repeat (2) @(negedge clk);
        check1(surr, 1'b0, "surround override");
        rep_mode = 1'b0;
        aux_wr = 1'b1;
        @(negedge clk);
        aux_wr = 1'b0;
        read_expect(ADDR_DP_CTRL, 8'h03);
        check1(aux, 1'b0, "aux from bridge");
        reg_write(ADDR_DP_CTRL, 8'hFC);
        read_expect(ADDR_DP_CTRL, 8'h00);
        check1(wide, 1'b0, "narrow word");
    endtask

    task automatic t_error_count();
        errors_for(2'b01, 3);
        read_expect(ADDR_ERR_COUNT, 8'h00);
        st_active = 1'b1;
        errors_for(2'b01, 260);
        read_expect(ADDR_ERR_COUNT, 8'hFF);
        errors_for(2'b10, 3);
        view_sel = 1'b1;
        read_expect(ADDR_ERR_COUNT, 8'h03);
        view_sel = 1'b0;
        reg_write(ADDR_ERR_COUNT, 8'h00);
        read_expect(ADDR_ERR_COUNT, 8'hFF);
        cnt_clear = 1'b1;
        @(negedge clk);
        cnt_clear = 1'b0;
        read_expect(ADDR_ERR_COUNT, 8'h00);
        errors_for(2'b10, 2);
        addr2_en = 1'b1;
        via_addr2 = 1'b1;
        read_expect(ADDR_ERR_COUNT, 8'h02);
        via_addr2 = 1'b0;
        view_sel = 1'b1;
        read_expect(ADDR_ERR_COUNT, 8'h00);
        view_sel = 1'b0;
        st_start = 1'b1;
        @(negedge clk);
        st_start = 1'b0;
        addr2_en = 1'b1;
        via_addr2 = 1'b1;
        read_expect(ADDR_ERR_COUNT, 8'h00);
        addr2_en = 1'b0;
        via_addr2 = 1'b0;
        st_active = 1'b0;
    endtask

    task automatic t_pins();
        pin_lvl = 9'h1B5;
        pin_mode = 9'h17F;
        pin2_lvl = 4'hA;
        pin2_mode = 4'hF;
        repeat (3) @(negedge clk);
        read_expect(ADDR_PIN_ONE, 8'h25);
        read_expect(ADDR_PIN_TWO, 8'h01);
        view_sel = 1'b1;
        read_expect(ADDR_PIN_ONE, 8'h2A);
        view_sel = 1'b0;
        pin_lvl = 9'h195;
        read_expect(ADDR_PIN_ONE, 8'h25);
        read_expect(ADDR_PIN_ONE, 8'h05);
        pin_mode = 9'h000;
        repeat (3) @(negedge clk);
        read_expect(ADDR_PIN_ONE, 8'h00);
        read_expect(ADDR_PIN_TWO, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        t_reset_values();
        t_low_time();
        t_data_path();
        t_error_count();
        t_pins();
        test_done();
    end

endmodule // sercfg_regs_tb

`default_nettype wire
